// [rtl/cas_core_end.sv]
`timescale 1ns/10ps
module cas_core_end (
  input wire logic aclk,
  input wire logic aresetn,
  cas_link_if.core link,
  input wire logic fw_halt_req,
  input wire logic bkpt_hit,
  input wire logic bus_idle,
  input wire logic stop_count,
  input wire logic [1:0] timer_enable,
  input wire logic [1:0] timer_halt_en,
  output logic stop_issue,
  output logic fine_gate_en,
  output logic enhanced_gate_en,
  output logic stepping,
  output logic [1:0] activity_state,
  output logic [1:0][cas_pkg::CNT_W-1:0] internal_timer_count,
  output logic [cas_pkg::CNT_W-1:0] cycle_count
);
  cas_pkg::cas_state_e state_r;
  cas_pkg::cas_state_e state_nxt;
  logic quiesce_r;
  logic quiesce_nxt;
  logic dh_r;
  logic dh_nxt;
  logic mh_r;
  logic mh_nxt;
  logic step_pend_r;
  logic step_pend_nxt;
  logic stepping_r;
  logic stepping_nxt;
  logic pm_halt_ack_r;
  logic pm_halt_ack_nxt;
  logic pm_run_ack_r;
  logic pm_run_ack_nxt;

  // State decode.
  wire logic is_run = state_r == cas_pkg::st_running;
  wire logic is_dbg = state_r == cas_pkg::st_debug;
  wire logic is_slp = state_r == cas_pkg::st_sleep;

  // Halt sources. Debug always outranks the power manager and firmware.
  wire logic dh_set = link.dbg_halt_req | bkpt_hit;
  wire logic mh_set = link.mc_halt_req;
  wire logic want_dbg = dh_r | mh_r;
  wire logic want_sleep = (link.pm_halt_req | fw_halt_req) & ~want_dbg;
  wire logic halt_done = quiesce_r & bus_idle;

  // Resume decode, only looked at while debug-halted.
  wire logic resume_go = is_dbg & dh_r & link.dbg_resume_req & ~link.dbg_step_req;
  wire logic run_go = is_dbg & mh_r & link.mc_run_req;
  wire logic step_req = is_dbg & dh_r & link.dbg_resume_req & link.dbg_step_req;
  wire logic step_now = (step_req | (is_dbg & step_pend_r)) & (~mh_r | run_go);
  wire logic step_hold = step_req & mh_r & ~run_go;
  // Each set bit needs its own matching request in the same cycle.
  // Anything else leaves the state untouched.
  wire logic leave_dbg = is_dbg & ~step_now & ~step_pend_r & want_dbg
                       & (~dh_r | resume_go) & (~mh_r | run_go);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      cas_pkg::st_running: begin
        if (stepping_r) begin
          state_nxt = cas_pkg::st_debug;
        end else if (halt_done & want_dbg) begin
          state_nxt = cas_pkg::st_debug;
        end else if (halt_done & want_sleep) begin
          state_nxt = cas_pkg::st_sleep;
        end
      end
      cas_pkg::st_debug: begin
        if (leave_dbg | step_now) begin
          state_nxt = cas_pkg::st_running;
        end
      end
      cas_pkg::st_sleep: begin
        if (want_dbg) begin
          state_nxt = cas_pkg::st_debug;
        end else if (link.pm_run_req) begin
          state_nxt = cas_pkg::st_running;
        end
      end
      default: begin
        state_nxt = cas_pkg::st_running;
      end
    endcase
  end

  // Issue stops from the cycle after a halt is wanted (quiesce is registered), and the halt itself waits
  // for the bus to drain so no transaction is cut in half.
  assign quiesce_nxt = is_run & ~stepping_r & (want_dbg | want_sleep)
                     & (state_nxt == cas_pkg::st_running);

  // A new halt request wins over the clear in the same cycle.
  assign dh_nxt = dh_set | (dh_r & ~leave_dbg);
  assign mh_nxt = mh_set | (mh_r & ~leave_dbg & ~step_now);
  assign step_pend_nxt = step_hold | (step_pend_r & ~step_now);
  assign stepping_nxt = step_now;

  // Power manager handshakes are four-phase levels.
  assign pm_halt_ack_nxt = link.pm_halt_req & (pm_halt_ack_r
                         | (is_run & state_nxt == cas_pkg::st_sleep));
  assign pm_run_ack_nxt = link.pm_run_req & (pm_run_ack_r
                        | (is_slp & state_nxt == cas_pkg::st_running));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= cas_pkg::st_running;
      quiesce_r <= 1'b0;
      dh_r <= 1'b0;
      mh_r <= 1'b0;
      step_pend_r <= 1'b0;
      stepping_r <= 1'b0;
      pm_halt_ack_r <= 1'b0;
      pm_run_ack_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      quiesce_r <= quiesce_nxt;
      dh_r <= dh_nxt;
      mh_r <= mh_nxt;
      step_pend_r <= step_pend_nxt;
      stepping_r <= stepping_nxt;
      pm_halt_ack_r <= pm_halt_ack_nxt;
      pm_run_ack_r <= pm_run_ack_nxt;
    end
  end

  // Acks to the debug side are one-cycle pulses so that the requester can
  // drop its level at the very edge that completes the exchange.
  assign link.dbg_resume_ack = (leave_dbg & dh_r) | (step_req & (step_now | step_hold));
  assign link.mc_run_ack = (leave_dbg & mh_r) | (step_now & mh_r);
  assign link.pm_halt_ack = pm_halt_ack_r;
  assign link.pm_run_ack = pm_run_ack_r;
  assign link.halt_status = is_slp;
  assign link.debug_mode_status = is_dbg | stepping_r;
  assign link.debug_halt_bit = dh_r;

  assign stop_issue = quiesce_r | ~is_run;
  assign fine_gate_en = 1'b1;
  assign enhanced_gate_en = is_slp;
  assign stepping = stepping_r;
  assign activity_state = state_r;

  // A single-stepped instruction runs in the running state, so timers
  // count through it while the rest of debug mode keeps them frozen.
  wire logic timer0_inc = timer_enable[0] & (is_run | (is_slp & timer_halt_en[0]));
  wire logic timer1_inc = timer_enable[1] & (is_run | (is_slp & timer_halt_en[1]));

  cas_counter #(
    .W(cas_pkg::CNT_W)
  ) u_timer0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .inc(timer0_inc),
    .count(internal_timer_count[0])
  );

  cas_counter #(
    .W(cas_pkg::CNT_W)
  ) u_timer1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .inc(timer1_inc),
    .count(internal_timer_count[1])
  );

  wire logic cycle_inc = is_run | (is_dbg & ~stop_count);

  cas_counter #(
    .W(cas_pkg::CNT_W)
  ) u_cycle (
    .aclk(aclk),
    .aresetn(aresetn),
    .inc(cycle_inc),
    .count(cycle_count)
  );
endmodule

// [rtl/cas_pkg.sv]
package cas_pkg;
  localparam int CNT_W = 32;
  localparam logic [31:0] CNT_RESET = 32'h0000_0000;
  typedef enum logic [1:0] {
    st_running = 2'b00,
    st_debug = 2'b01,
    st_sleep = 2'b10
  } cas_state_e;
  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_REFUSE = 8'h08;
  localparam int CMD_PM_HALT = 0;
  localparam int CMD_PM_RUN = 1;
  localparam int CMD_MC_HALT = 2;
  localparam int CMD_MC_RUN = 3;
  localparam int CMD_DBG_HALT = 4;
  localparam int CMD_RESUME = 5;
  localparam int CMD_STEP = 6;
  localparam int ST_HALTED = 0;
  localparam int ST_DEBUG = 1;
  localparam int ST_PM_HALT_ACK = 2;
  localparam int ST_PM_RUN_ACK = 3;
  localparam int ST_DH_BIT = 4;
  localparam int ST_MC_HALTED = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [rtl/cas_link_if.sv]
`timescale 1ns/10ps
interface cas_link_if;
  logic pm_halt_req;
  logic pm_halt_ack;
  logic pm_run_req;
  logic pm_run_ack;
  logic halt_status;
  logic mc_halt_req;
  logic mc_run_req;
  logic mc_run_ack;
  logic dbg_halt_req;
  logic dbg_resume_req;
  logic dbg_step_req;
  logic dbg_resume_ack;
  logic debug_mode_status;
  logic debug_halt_bit;
  modport core (
    input pm_halt_req,
    output pm_halt_ack,
    input pm_run_req,
    output pm_run_ack,
    output halt_status,
    input mc_halt_req,
    input mc_run_req,
    output mc_run_ack,
    input dbg_halt_req,
    input dbg_resume_req,
    input dbg_step_req,
    output dbg_resume_ack,
    output debug_mode_status,
    output debug_halt_bit
  );
  modport ctrl (
    output pm_halt_req,
    input pm_halt_ack,
    output pm_run_req,
    input pm_run_ack,
    input halt_status,
    output mc_halt_req,
    output mc_run_req,
    input mc_run_ack,
    output dbg_halt_req,
    output dbg_resume_req,
    output dbg_step_req,
    input dbg_resume_ack,
    input debug_mode_status,
    input debug_halt_bit
  );
endinterface

// [rtl/cas_counter.sv]
`timescale 1ns/10ps
module cas_counter #(
  parameter int W = cas_pkg::CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic inc,
  output logic [W-1:0] count
);
  logic [W-1:0] count_r;
  wire logic [W-1:0] count_nxt = inc ? count_r + {{(W-1){1'b0}}, 1'b1} : count_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= W'(cas_pkg::CNT_RESET);
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;
endmodule

// [rtl/cas_ctrl_end.sv]
`timescale 1ns/10ps
module cas_ctrl_end (
  input wire logic aclk,
  input wire logic aresetn,
  cas_link_if.ctrl link,
  input wire logic [cas_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cas_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic aw_full_r, w_full_r, bvalid_r, rvalid_r;
  logic [cas_pkg::AXI_AW-1:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic wstrb0_r;
  logic [1:0] bresp_r, rresp_r;
  logic pm_halt_r, pm_run_r, mc_run_r, resume_r, step_r;
  logic mc_halt_p_r, dbg_halt_p_r, last_mc_halt_r, refused_r;

  wire logic aw_hs = s_axi_awvalid & s_axi_awready;
  wire logic w_hs = s_axi_wvalid & s_axi_wready;
  wire logic ar_hs = s_axi_arvalid & s_axi_arready;
  wire logic wr_go = aw_full_r & w_full_r & ~bvalid_r;
  wire logic wr_cmd = wr_go & wstrb0_r & (awaddr_r == cas_pkg::REG_CMD);
  wire logic wr_ref = wr_go & wstrb0_r & (awaddr_r == cas_pkg::REG_REFUSE);
  wire logic wr_map = (awaddr_r == cas_pkg::REG_CMD) | (awaddr_r == cas_pkg::REG_STATUS)
                    | (awaddr_r == cas_pkg::REG_REFUSE);

  // Command gating keeps the far side inside its legal request order.
  wire logic pm_idle = ~pm_halt_r & ~pm_run_r & ~link.pm_halt_ack & ~link.pm_run_ack;
  wire logic ok_pm_halt = pm_idle;
  wire logic ok_pm_run = pm_idle;
  wire logic ok_mc_halt = ~last_mc_halt_r & (~link.debug_mode_status | link.debug_halt_bit);
  wire logic ok_mc_run = last_mc_halt_r & link.debug_mode_status & ~mc_run_r;
  wire logic ok_resume = link.debug_halt_bit & ~resume_r;
  wire logic c_pm_halt = wr_cmd & wdata_r[cas_pkg::CMD_PM_HALT];
  wire logic c_pm_run = wr_cmd & wdata_r[cas_pkg::CMD_PM_RUN];
  wire logic c_mc_halt = wr_cmd & wdata_r[cas_pkg::CMD_MC_HALT];
  wire logic c_mc_run = wr_cmd & wdata_r[cas_pkg::CMD_MC_RUN];
  wire logic c_resume = wr_cmd & wdata_r[cas_pkg::CMD_RESUME];
  wire logic go_pm_halt = c_pm_halt & ok_pm_halt & ~c_pm_run;
  wire logic go_pm_run = c_pm_run & ok_pm_run & ~c_pm_halt;
  wire logic go_mc_halt = c_mc_halt & ok_mc_halt;
  wire logic go_mc_run = c_mc_run & ok_mc_run;
  wire logic go_resume = c_resume & ok_resume;
  wire logic refuse = (c_pm_halt & ~go_pm_halt) | (c_pm_run & ~go_pm_run) | (c_mc_halt & ~go_mc_halt)
                    | (c_mc_run & ~go_mc_run) | (c_resume & ~go_resume);

  wire logic [31:0] status_w = {26'h0, last_mc_halt_r, link.debug_halt_bit, link.pm_run_ack,
                                link.pm_halt_ack, link.debug_mode_status, link.halt_status};
  wire logic [31:0] cmd_w = {25'h0, step_r, resume_r, 1'b0, mc_run_r, 1'b0, pm_run_r, pm_halt_r};
  wire logic ar_cmd = s_axi_araddr == cas_pkg::REG_CMD;
  wire logic ar_st = s_axi_araddr == cas_pkg::REG_STATUS;
  wire logic ar_ref = s_axi_araddr == cas_pkg::REG_REFUSE;
  wire logic [31:0] rd_mux = ar_cmd ? cmd_w : ar_st ? status_w : ar_ref ? {31'h0, refused_r} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb0_r <= 1'b0;
      rdata_r <= 32'h0;
      bresp_r <= cas_pkg::RESP_OKAY;
      rresp_r <= cas_pkg::RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_full_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_full_r <= 1'b0;
      end
      if (w_hs) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_full_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_map ? cas_pkg::RESP_OKAY : cas_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (ar_hs) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= (ar_cmd | ar_st | ar_ref) ? cas_pkg::RESP_OKAY : cas_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Requests are levels dropped on the matching ack; controller and debug halts are pulses.
  // A refusal sets a sticky flag, and setting wins over the software clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pm_halt_r <= 1'b0;
      pm_run_r <= 1'b0;
      mc_run_r <= 1'b0;
      resume_r <= 1'b0;
      step_r <= 1'b0;
      mc_halt_p_r <= 1'b0;
      dbg_halt_p_r <= 1'b0;
      last_mc_halt_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      pm_halt_r <= go_pm_halt | (pm_halt_r & ~link.pm_halt_ack);
      pm_run_r <= go_pm_run | (pm_run_r & ~link.pm_run_ack);
      mc_run_r <= go_mc_run | (mc_run_r & ~link.mc_run_ack);
      resume_r <= go_resume | (resume_r & ~link.dbg_resume_ack);
      step_r <= go_resume ? wdata_r[cas_pkg::CMD_STEP] : (step_r & ~link.dbg_resume_ack);
      mc_halt_p_r <= go_mc_halt;
      dbg_halt_p_r <= wr_cmd & wdata_r[cas_pkg::CMD_DBG_HALT];
      last_mc_halt_r <= go_mc_halt | (last_mc_halt_r & ~go_mc_run);
      refused_r <= refuse | (refused_r & ~(wr_ref & wdata_r[0]));
    end
  end

  assign s_axi_awready = ~aw_full_r & ~bvalid_r;
  assign s_axi_wready = ~w_full_r & ~bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign link.pm_halt_req = pm_halt_r;
  assign link.pm_run_req = pm_run_r;
  assign link.mc_halt_req = mc_halt_p_r;
  assign link.mc_run_req = mc_run_r;
  assign link.dbg_halt_req = dbg_halt_p_r;
  assign link.dbg_resume_req = resume_r;
  assign link.dbg_step_req = step_r;
endmodule

// [tb/cas_properties.sv]
`timescale 1ns/10ps
module cas_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pm_halt_req,
  input wire logic pm_halt_ack,
  input wire logic pm_run_req,
  input wire logic pm_run_ack,
  input wire logic halt_status,
  input wire logic mc_halt_req,
  input wire logic mc_run_req,
  input wire logic mc_run_ack,
  input wire logic dbg_halt_req,
  input wire logic dbg_resume_req,
  input wire logic dbg_step_req,
  input wire logic dbg_resume_ack,
  input wire logic debug_mode_status,
  input wire logic debug_halt_bit
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire no_halt_pulse = !dbg_halt_req && !mc_halt_req;
  property p_resume_cause;
    dbg_resume_ack |-> dbg_resume_req && debug_halt_bit;
  endproperty
  a_resume_cause: assert property (p_resume_cause) else $error("resume ack without request or halt bit");
  property p_run_cause;
    mc_run_ack |-> mc_run_req;
  endproperty
  a_run_cause: assert property (p_run_cause) else $error("run ack without request");
  property p_leave_clears;
    dbg_resume_ack && !dbg_step_req && no_halt_pulse |=> !debug_halt_bit && !debug_mode_status;
  endproperty
  a_leave_clears: assert property (p_leave_clears) else $error("halt bits kept after leaving debug");
  property p_no_lone_run;
    debug_halt_bit && dbg_resume_req && !dbg_resume_ack |-> !mc_run_ack;
  endproperty
  a_no_lone_run: assert property (p_no_lone_run) else $error("run acked while resume still waits");
  property p_both_leave;
    dbg_resume_ack && mc_run_ack && no_halt_pulse |=> !debug_mode_status ##1 !debug_mode_status;
  endproperty
  a_both_leave: assert property (p_both_leave) else $error("core stayed halted after both acks");
  property p_stay_halted;
    debug_mode_status && debug_halt_bit && !dbg_resume_req |=> debug_mode_status;
  endproperty
  a_stay_halted: assert property (p_stay_halted) else $error("debug halt left without resume");
  property p_sleep_flags;
    halt_status |-> !debug_mode_status;
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("halted and debug mode together");
  property p_ack_rise;
    $rose(pm_halt_ack) |-> halt_status && pm_halt_req;
  endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("halt ack before sleep");
  property p_ack_hold;
    pm_halt_ack |=> pm_halt_ack == $past(pm_halt_req);
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("halt ack does not follow request");
  property p_wake;
    pm_run_req && halt_status && !pm_run_ack && no_halt_pulse |=> pm_run_ack && !halt_status;
  endproperty
  a_wake: assert property (p_wake) else $error("run request did not wake the core");
  c_both: cover property (dbg_resume_ack && mc_run_ack);
  c_sleep: cover property ($rose(pm_halt_ack));
  c_step: cover property (dbg_resume_ack && dbg_step_req);
  c_wake: cover property ($rose(pm_run_ack));
endmodule

// [tb/core_activity_state_control_tb.sv]
`timescale 1ns/10ps
module core_activity_state_control_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic fw_halt_req = 1'b0;
  logic bkpt_hit = 1'b0;
  logic bus_idle = 1'b1;
  logic stop_count = 1'b0;
  logic [1:0] timer_enable = 2'h0;
  logic [1:0] timer_halt_en = 2'h0;
  logic stop_issue, fine_gate_en, enhanced_gate_en, stepping, pq, seen;
  logic [1:0] activity_state;
  logic [1:0][cas_pkg::CNT_W-1:0] internal_timer_count, etim;
  logic [cas_pkg::CNT_W-1:0] cycle_count, ecyc;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, rnd, rd;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  wire is_run = activity_state == cas_pkg::st_running;
  wire is_dbg = activity_state == cas_pkg::st_debug;
  wire is_slp = activity_state == cas_pkg::st_sleep;
  always #2.5 aclk = ~aclk;
  cas_link_if i_cas_link_if ();
  cas_core_end i_cas_core_end (.aclk(aclk), .aresetn(aresetn), .link(i_cas_link_if), .fw_halt_req(fw_halt_req),
    .bkpt_hit(bkpt_hit), .bus_idle(bus_idle), .stop_count(stop_count), .timer_enable(timer_enable),
    .timer_halt_en(timer_halt_en), .stop_issue(stop_issue), .fine_gate_en(fine_gate_en),
    .enhanced_gate_en(enhanced_gate_en), .stepping(stepping), .activity_state(activity_state),
    .internal_timer_count(internal_timer_count), .cycle_count(cycle_count));
  cas_ctrl_end i_cas_ctrl_end (.aclk(aclk), .aresetn(aresetn), .link(i_cas_link_if), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
  cas_properties i_cas_properties (.aclk(aclk), .aresetn(aresetn), .pm_halt_req(i_cas_link_if.pm_halt_req),
    .pm_halt_ack(i_cas_link_if.pm_halt_ack), .pm_run_req(i_cas_link_if.pm_run_req),
    .pm_run_ack(i_cas_link_if.pm_run_ack), .halt_status(i_cas_link_if.halt_status),
    .mc_halt_req(i_cas_link_if.mc_halt_req), .mc_run_req(i_cas_link_if.mc_run_req),
    .mc_run_ack(i_cas_link_if.mc_run_ack), .dbg_halt_req(i_cas_link_if.dbg_halt_req),
    .dbg_resume_req(i_cas_link_if.dbg_resume_req), .dbg_step_req(i_cas_link_if.dbg_step_req),
    .dbg_resume_ack(i_cas_link_if.dbg_resume_ack), .debug_mode_status(i_cas_link_if.debug_mode_status),
    .debug_halt_bit(i_cas_link_if.debug_halt_bit));
  function automatic logic [31:0] inc(input logic [31:0] v, input logic c);
    return v + {31'h0, c};
  endfunction
  function automatic logic [31:0] st_word(input logic h, input logic d, input logic b);
    return {27'h0, b, 2'h0, d, h};
  endfunction
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Random control bits every cycle exercise the counter gating in all three states.
  always @(posedge aclk) begin
    rnd = $urandom;
    stop_count <= rnd[0];
    timer_enable <= rnd[2:1];
    timer_halt_en <= rnd[4:3];
    bus_idle <= |rnd[6:5];
    if (!aresetn) begin
      ecyc <= 32'h0;
      etim <= 64'h0;
    end else begin
      ecyc <= inc(ecyc, is_run || (is_dbg && !stop_count));
      for (int i = 0; i < 2; i++) begin
        etim[i] <= inc(etim[i], timer_enable[i] && (is_run || (is_slp && timer_halt_en[i])));
      end
    end
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      $display("[FAIL] %0t timeout", $time);
      conclude();
    end
  end
  always @(negedge aclk) begin
    if (aresetn) begin
      chk(activity_state !== 2'b11, "state encoding");
      chk(i_cas_link_if.halt_status === is_slp && enhanced_gate_en === is_slp, "sleep signals");
      chk(i_cas_link_if.debug_mode_status === (is_dbg || stepping), "debug signal");
      chk(fine_gate_en === 1'b1, "fine gating");
      chk(cycle_count === ecyc && internal_timer_count === etim, "counters");
      chk(!(pq && !is_run), "halt without quiesce");
    end
    pq = is_run && stop_issue !== 1'b1 && stepping !== 1'b1;
  end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
  endtask
  task automatic cmd(input logic [31:0] d);
    axi_wr(cas_pkg::REG_CMD, d);
    repeat ($urandom_range(4, 12)) @(posedge aclk);
  endtask
  task automatic wait_st(input logic [1:0] s);
    for (int k = 0; k < 300 && activity_state !== s; k++) @(posedge aclk);
    chk(activity_state === s, "state not reached");
    repeat (6) @(posedge aclk);
  endtask
  task automatic wait_step;
    for (int k = 0; k < 300 && stepping !== 1'b1; k++) @(posedge aclk);
    chk(stepping === 1'b1, "step not executed");
  endtask
  task automatic status(input logic [31:0] e);
    axi_rd(cas_pkg::REG_STATUS);
    chk((rd & 32'h13) === e, "status word");
  endtask
  initial begin
    void'($urandom(92951));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    status(st_word(1'b0, 1'b0, 1'b0));
    axi_rd(8'h0c);
    chk(rsp === cas_pkg::RESP_SLVERR && rd === 32'h0, "unmapped read");
    axi_wr(8'h0c, 32'h1f);
    chk(rsp === cas_pkg::RESP_SLVERR && is_run, "unmapped write");
    cmd(32'h1);
    chk(rsp === cas_pkg::RESP_OKAY, "command write response");
    wait_st(cas_pkg::st_sleep);
    status(st_word(1'b1, 1'b0, 1'b0));
    cmd(32'h2);
    wait_st(cas_pkg::st_running);
    fw_halt_req <= 1'b1;
    wait_st(cas_pkg::st_sleep);
    fw_halt_req <= 1'b0;
    cmd(32'h2);
    wait_st(cas_pkg::st_running);
    cmd(32'h10);
    wait_st(cas_pkg::st_debug);
    status(st_word(1'b0, 1'b1, 1'b1));
    cmd(32'h20);
    wait_st(cas_pkg::st_running);
    status(st_word(1'b0, 1'b0, 1'b0));
    cmd(32'h10);
    cmd(32'h4);
    wait_st(cas_pkg::st_debug);
    cmd(32'h20);
    repeat (20) @(posedge aclk);
    chk(activity_state === cas_pkg::st_debug, "left with resume only");
    cmd(32'h8);
    wait_st(cas_pkg::st_running);
    cmd(32'h4);
    wait_st(cas_pkg::st_debug);
    cmd(32'h20);
    axi_rd(cas_pkg::REG_REFUSE);
    chk(rd[0] === 1'b1 && activity_state === cas_pkg::st_debug, "resume without halt bit");
    axi_wr(cas_pkg::REG_REFUSE, 32'h1);
    cmd(32'h8);
    wait_st(cas_pkg::st_running);
    axi_rd(cas_pkg::REG_REFUSE);
    chk(rd[0] === 1'b0, "refusal not cleared");
    cmd(32'h8);
    axi_rd(cas_pkg::REG_REFUSE);
    chk(rd[0] === 1'b1, "second run not refused");
    axi_wr(cas_pkg::REG_REFUSE, 32'h1);
    cmd(32'h10);
    wait_st(cas_pkg::st_debug);
    axi_wr(cas_pkg::REG_CMD, 32'h60);
    wait_step();
    wait_st(cas_pkg::st_debug);
    status(st_word(1'b0, 1'b1, 1'b1));
    cmd(32'h4);
    cmd(32'h60);
    seen = 1'b0;
    repeat (30) begin
      @(posedge aclk);
      if (stepping === 1'b1) seen = 1'b1;
    end
    chk(!seen, "step ran before controller run");
    axi_wr(cas_pkg::REG_CMD, 32'h8);
    wait_step();
    wait_st(cas_pkg::st_debug);
    cmd(32'h20);
    wait_st(cas_pkg::st_running);
    bkpt_hit <= 1'b1;
    @(posedge aclk);
    bkpt_hit <= 1'b0;
    wait_st(cas_pkg::st_debug);
    cmd(32'h20);
    wait_st(cas_pkg::st_running);
    repeat (50) @(posedge aclk);
    conclude();
  end
endmodule
